// [design/audio_ctrl_slave.sv]
// Purpose: Write-only serial bus slave holding the sound processor settings
// Assumes: scl_i is the link clock; sda is open drain; mute_n_i and zero_cross_i are asynchronous
// Notes:   Bit capture runs on scl_i, framing and registers on clk_i
//
// Functional notes
// - Only the write address byte 0x80 is answered after a start.
// - Acknowledge is driven after address, subaddress and every data byte.
// - Subaddress advances after each data byte so the next byte hits the next register.
// - Subaddress bits 2..0 select one of the eight setting registers.
// - Volume byte: bit 7 zero-cross mode, bit 6 contour off, bits 5..0 volume.
// - Each attenuator byte keeps bits 5..0; bits 7..6 ignored.
// - Low and high tone bytes keep bits 4..0; bits 7..5 ignored.
// - Switch byte: bit 7 silence flag, bits 2..0 source code.
// - One transfer of eight data bytes from subaddress 0 loads every register.
// - Reset forces the silence flag set so all outputs are muted.
// - Reset holds the receiver idle; no transfer is accepted.
// - Hardware mute is released well within 0.5 ms after the pin goes high.
// - Without zero-cross mode silence changes at once; with it, per channel at zero crossing.
// - A pending delayed mute is forced after 100 ms, restarted by each switch byte.
// - Low mute pin mutes all outputs immediately without storing anything.
`timescale 1ns/1ps

module audio_ctrl_slave
    import audio_ctrl_pkg::*;
#(
    parameter int unsigned ZC_TIMEOUT = ZC_TIMEOUT_CYCLES
) (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe_n_o,
    input  wire logic                      mute_n_i,
    input  wire logic [NUM_CHANNELS-1:0]   zero_cross_i,
    output settings_type                   settings_o,
    output logic      [NUM_CHANNELS-1:0]   channel_mute_o
);

    // ----------------------------------------------------------------
    // Link clock domain: bit capture
    // ----------------------------------------------------------------
    logic [7:0] link_shift_reg;
    logic       link_bit_tgl_reg;

    // Data is stable while the link clock is high, so it is taken on the rise
    always_ff @(posedge scl_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_shift_reg   <= 8'h00;
            link_bit_tgl_reg <= 1'b0;
        end else begin
            link_shift_reg   <= {link_shift_reg[6:0], sda_i};
            link_bit_tgl_reg <= ~link_bit_tgl_reg;
        end
    end

    // ----------------------------------------------------------------
    // Synchronisers into the system clock
    // ----------------------------------------------------------------
    logic                    scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic                    sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic                    tgl_meta_reg, tgl_sync_reg, tgl_prev_reg;
    logic                    mute_meta_reg, mute_sync_reg;
    logic [NUM_CHANNELS-1:0] zc_meta_reg, zc_sync_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_meta_reg  <= 1'b1;
            scl_sync_reg  <= 1'b1;
            scl_prev_reg  <= 1'b1;
            sda_meta_reg  <= 1'b1;
            sda_sync_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
            tgl_meta_reg  <= 1'b0;
            tgl_sync_reg  <= 1'b0;
            tgl_prev_reg  <= 1'b0;
            mute_meta_reg <= 1'b1;
            mute_sync_reg <= 1'b1;
            zc_meta_reg   <= '0;
            zc_sync_reg   <= '0;
        end else begin
            scl_meta_reg  <= scl_i;
            scl_sync_reg  <= scl_meta_reg;
            scl_prev_reg  <= scl_sync_reg;
            sda_meta_reg  <= sda_i;
            sda_sync_reg  <= sda_meta_reg;
            sda_prev_reg  <= sda_sync_reg;
            tgl_meta_reg  <= link_bit_tgl_reg;
            tgl_sync_reg  <= tgl_meta_reg;
            tgl_prev_reg  <= tgl_sync_reg;
            mute_meta_reg <= mute_n_i;
            mute_sync_reg <= mute_meta_reg;
            zc_meta_reg   <= zero_cross_i;
            zc_sync_reg   <= zc_meta_reg;
        end
    end

    logic start_seen;
    logic stop_seen;
    logic bit_seen;
    logic scl_fall;

    assign start_seen = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
    assign stop_seen  = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
    assign bit_seen   = tgl_sync_reg ^ tgl_prev_reg;
    assign scl_fall   = scl_prev_reg && !scl_sync_reg;

    function automatic logic [2:0] next_select(input logic [2:0] sel);
        // Three bits wrap naturally from the switch register to volume
        return sel + 3'h1;
    endfunction

    // ----------------------------------------------------------------
    // Framing state machine
    // ----------------------------------------------------------------
    rx_state_type  state_reg;
    bit_count_type bit_cnt_reg;
    logic [2:0]    select_reg;
    logic          ack_pending_reg;
    logic          byte_done;
    logic [7:0]    rx_byte;

    // The shift word is read only once its toggle has crossed; it stays put until the next rise
    assign byte_done = bit_seen && (bit_cnt_reg == LAST_DATA_BIT) &&
                       (state_reg inside {ST_ADDR, ST_SUB, ST_DATA});
    assign rx_byte   = link_shift_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= '0;
            select_reg  <= REG_VOLUME_LOUDNESS;
        end else if (start_seen) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= '0;
        end else if (stop_seen) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= '0;
        end else if (bit_seen) begin
            bit_cnt_reg <= (bit_cnt_reg == ACK_BIT) ? '0 : bit_cnt_reg + 4'h1;
            if (byte_done) begin
                unique case (state_reg)
                    ST_ADDR: begin
                        // Read requests differ in bit 0 and fall out here too
                        state_reg <= (rx_byte == DEVICE_BUS_ADDRESS) ? ST_SUB : ST_SKIP;
                    end
                    ST_SUB: begin
                        select_reg <= rx_byte[2:0];
                        state_reg  <= ST_DATA;
                    end
                    ST_DATA: begin
                        select_reg <= next_select(select_reg);
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Acknowledge driver
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_pending_reg <= 1'b0;
            sda_oe_n_o      <= 1'b1;
        end else if (start_seen || stop_seen) begin
            ack_pending_reg <= 1'b0;
            sda_oe_n_o      <= 1'b1;
        end else if (byte_done) begin
            ack_pending_reg <= (state_reg != ST_ADDR) || (rx_byte == DEVICE_BUS_ADDRESS);
        end else if (scl_fall) begin
            // Pull low for the ninth bit, let go on the fall that ends it
            sda_oe_n_o      <= !ack_pending_reg;
            ack_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Setting registers
    // ----------------------------------------------------------------
    settings_type settings_reg;
    logic         data_write;
    logic         switch_write;

    assign data_write   = byte_done && (state_reg == ST_DATA);
    assign switch_write = data_write && (select_reg == REG_INPUT_SELECT_MUTE);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settings_reg <= SETTINGS_RESET;
        end else if (data_write) begin
            unique case (select_reg)
                REG_VOLUME_LOUDNESS: begin
                    settings_reg.zero_cross_mode_flag <= rx_byte[ZERO_CROSS_MODE_BIT];
                    settings_reg.contour_disable_flag <= rx_byte[CONTOUR_DISABLE_BIT];
                    settings_reg.volume_code          <= rx_byte[5:0];
                end
                REG_FRONT_RIGHT_ATT: settings_reg.front_right_attenuator <= rx_byte[5:0];
                REG_FRONT_LEFT_ATT:  settings_reg.front_left_attenuator  <= rx_byte[5:0];
                REG_REAR_RIGHT_ATT:  settings_reg.rear_right_attenuator  <= rx_byte[5:0];
                REG_REAR_LEFT_ATT:   settings_reg.rear_left_attenuator   <= rx_byte[5:0];
                REG_LOW_TONE:        settings_reg.low_tone_setting       <= rx_byte[4:0];
                REG_HIGH_TONE:       settings_reg.high_tone_setting      <= rx_byte[4:0];
                REG_INPUT_SELECT_MUTE: begin
                    settings_reg.global_silence_flag <= rx_byte[GLOBAL_SILENCE_BIT];
                    settings_reg.source_code         <= rx_byte[2:0];
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settings_o <= SETTINGS_RESET;
        end else begin
            settings_o <= settings_reg;
        end
    end

    // ----------------------------------------------------------------
    // Delayed mute timeout
    // ----------------------------------------------------------------
    zc_count_type zc_cnt_reg;
    logic         zc_run_reg;
    logic         zc_timeout;

    assign zc_timeout = zc_run_reg && (zc_cnt_reg == zc_count_type'(ZC_TIMEOUT - 1));

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            zc_cnt_reg <= '0;
            zc_run_reg <= 1'b0;
        end else if (switch_write) begin
            zc_cnt_reg <= '0;
            zc_run_reg <= 1'b1;
        end else if (zc_timeout) begin
            zc_run_reg <= 1'b0;
        end else if (zc_run_reg) begin
            zc_cnt_reg <= zc_cnt_reg + zc_count_type'(1);
        end
    end

    // ----------------------------------------------------------------
    // Channel mute switches
    // ----------------------------------------------------------------
    logic [NUM_CHANNELS-1:0] applied_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            applied_reg <= '1;
        end else begin
            for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
                if (!settings_reg.zero_cross_mode_flag || zc_sync_reg[ch] || zc_timeout) begin
                    applied_reg[ch] <= settings_reg.global_silence_flag;
                end
            end
        end
    end

    // The pin acts on the output only; it never touches the stored flag
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            channel_mute_o <= '1;
        end else begin
            channel_mute_o <= applied_reg | {NUM_CHANNELS{!mute_sync_reg}};
        end
    end

endmodule // audio_ctrl_slave

// [design/audio_ctrl_pkg.sv]
// Purpose: Shared constants and types for the audio control bus slave
// Assumes: 200 MHz system clock, serial bus clock used as link clock
// Notes:   Setting registers are write-only from the bus side
package audio_ctrl_pkg;

    // ----------------------------------------------------------------
    // Bus addressing
    // ----------------------------------------------------------------
    localparam logic [7:0] DEVICE_BUS_ADDRESS       = 8'h80;
    localparam logic [2:0] REG_VOLUME_LOUDNESS      = 3'h0;
    localparam logic [2:0] REG_FRONT_RIGHT_ATT      = 3'h1;
    localparam logic [2:0] REG_FRONT_LEFT_ATT       = 3'h2;
    localparam logic [2:0] REG_REAR_RIGHT_ATT       = 3'h3;
    localparam logic [2:0] REG_REAR_LEFT_ATT        = 3'h4;
    localparam logic [2:0] REG_LOW_TONE             = 3'h5;
    localparam logic [2:0] REG_HIGH_TONE            = 3'h6;
    localparam logic [2:0] REG_INPUT_SELECT_MUTE    = 3'h7;

    // ----------------------------------------------------------------
    // Field positions inside the data byte
    // ----------------------------------------------------------------
    localparam int ZERO_CROSS_MODE_BIT  = 7;
    localparam int CONTOUR_DISABLE_BIT  = 6;
    localparam int GLOBAL_SILENCE_BIT   = 7;

    typedef logic [5:0] level_code_type;
    typedef logic [4:0] tone_code_type;
    typedef logic [2:0] source_code_type;

    typedef struct packed {
        logic            zero_cross_mode_flag;
        logic            contour_disable_flag;
        level_code_type  volume_code;
        level_code_type  front_right_attenuator;
        level_code_type  front_left_attenuator;
        level_code_type  rear_right_attenuator;
        level_code_type  rear_left_attenuator;
        tone_code_type   low_tone_setting;
        tone_code_type   high_tone_setting;
        logic            global_silence_flag;
        source_code_type source_code;
    } settings_type;

    // Everything cleared except the silence flag, which power-on forces set
    localparam settings_type SETTINGS_RESET = '{
        zero_cross_mode_flag   : 1'b0,
        contour_disable_flag   : 1'b0,
        volume_code            : 6'h00,
        front_right_attenuator : 6'h00,
        front_left_attenuator  : 6'h00,
        rear_right_attenuator  : 6'h00,
        rear_left_attenuator   : 6'h00,
        low_tone_setting       : 5'h00,
        high_tone_setting      : 5'h00,
        global_silence_flag    : 1'b1,
        source_code            : 3'h0
    };

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    typedef logic [3:0] bit_count_type;
    localparam bit_count_type LAST_DATA_BIT = 4'h7;
    localparam bit_count_type ACK_BIT       = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_SUB  = 5'b00100,
        ST_DATA = 5'b01000,
        ST_SKIP = 5'b10000
    } rx_state_type;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int NUM_CHANNELS      = 2;
    localparam int CLK_PERIOD_NS     = 5;
    localparam int ZC_TIMEOUT_US     = 100000;
    localparam int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    typedef logic [24:0] zc_count_type;

endpackage

// [verif/audio_ctrl_slave_asserts.sv]
// Purpose: Concurrent checks on the ports of the audio control bus slave
// Assumes: scl_i is slow against clk_i, so it is watched from the clk_i domain
// Notes:   Bound into every audio_ctrl_slave instance
`timescale 1ns/1ps

module audio_ctrl_slave_asserts
    import audio_ctrl_pkg::*;
#(
    parameter int unsigned ZC_TIMEOUT = ZC_TIMEOUT_CYCLES
) (
    input wire logic                    clk_i,
    input wire logic                    nrst_i,
    input wire logic                    scl_i,
    input wire logic                    sda_i,
    input wire logic                    sda_o,
    input wire logic                    sda_oe_n_o,
    input wire logic                    mute_n_i,
    input wire logic [NUM_CHANNELS-1:0] zero_cross_i,
    input wire settings_type            settings_o,
    input wire logic [NUM_CHANNELS-1:0] channel_mute_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Length of the current acknowledge; saturates so a stuck pull is still caught
    logic [5:0] ack_len_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) ack_len_reg <= 6'h00;
        else if (sda_oe_n_o) ack_len_reg <= 6'h00;
        else if (ack_len_reg != 6'h3f) ack_len_reg <= ack_len_reg + 6'h01;
    end

    sequence ack_begins; $fell(sda_oe_n_o); endsequence
    sequence hw_mute_held; !mute_n_i [*5]; endsequence
    sequence direct_open; (mute_n_i && !settings_o.global_silence_flag && !settings_o.zero_cross_mode_flag) [*8];
    endsequence
    sequence direct_shut; (mute_n_i && settings_o.global_silence_flag && !settings_o.zero_cross_mode_flag) [*4];
    endsequence

    hw_mute_a: assert property (hw_mute_held |-> channel_mute_o == 2'b11)
        else $error("hardware mute not applied");
    mute_release_a: assert property (direct_open |-> channel_mute_o == 2'b00)
        else $error("mute not released");
    direct_mute_a: assert property (direct_shut |-> channel_mute_o == 2'b11)
        else $error("direct silence not applied");
    ack_low_a: assert property (!sda_oe_n_o |-> sda_o == 1'b0)
        else $error("acknowledge drives high");
    ack_in_low_a: assert property (ack_begins |-> !scl_i)
        else $error("acknowledge starts while clock high");
    ack_stands_a: assert property (ack_begins |-> !sda_oe_n_o [*8])
        else $error("acknowledge too short");
    ack_ends_a: assert property (ack_len_reg < 6'd24)
        else $error("acknowledge held too long");
    settings_update_a: assert property ($changed(settings_o) |-> scl_i)
        else $error("settings change outside a data bit");
endmodule // audio_ctrl_slave_asserts

bind audio_ctrl_slave audio_ctrl_slave_asserts #(.ZC_TIMEOUT(ZC_TIMEOUT)) audio_ctrl_slave_asserts_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .mute_n_i(mute_n_i), .zero_cross_i(zero_cross_i), .settings_o(settings_o), .channel_mute_o(channel_mute_o));

// [verif/i2c_master_model.sv]
// Purpose: Bus master model that writes bytes to the slave
// Assumes: Open-drain data with pull-up resolved by the bench; 80 ns bit period
// Notes:   Clock stands high between frames
`timescale 1ns/1ps

module i2c_master_model (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic start;
        sda_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_o = 1'b0;
        #20 scl_o = 1'b0;
        #20;
    endtask

    // Sends one byte MSB first, then releases data and samples the acknowledge
    task automatic put(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_o = d[i];
            #20 scl_o = 1'b1;
            #40 scl_o = 1'b0;
            #20;
        end
        sda_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 ack = !sda_i;
        #20 scl_o = 1'b0;
        #20;
    endtask

    task automatic stop;
        sda_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_o = 1'b1;
        #40;
    endtask
endmodule // i2c_master_model

// [verif/audio_control_i2c_slave_test.sv]
// Purpose: Self-checking bench for the audio control bus slave
// Assumes: Bus master model on the far side; pull-up on the data line
// Notes:   Zero-cross timeout shortened to 200 cycles
`timescale 1ns/1ps

module audio_control_i2c_slave_test;
    import audio_ctrl_pkg::*;
    localparam int unsigned ZC_T = 200;
    logic         clk_i = 1'b0;
    logic         nrst_i = 1'b0;
    logic         mute_n_i = 1'b1;
    logic [1:0]   zero_cross_i = 2'b00;
    logic         sda_o;
    logic         sda_oe_n_o;
    logic [1:0]   channel_mute_o;
    settings_type settings_o;
    settings_type exp_s;
    wire          scl;
    wire          m_sda;
    wire          sda_line = m_sda & (sda_oe_n_o | sda_o);
    logic [7:0]   dq[$];
    int           mismatches = 0;
    int           n_compared = 0;
    int           n;

    always #2.5 clk_i = ~clk_i;

    audio_ctrl_slave #(.ZC_TIMEOUT(ZC_T)) audio_ctrl_slave_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .mute_n_i(mute_n_i), .zero_cross_i(zero_cross_i), .settings_o(settings_o), .channel_mute_o(channel_mute_o));
    i2c_master_model i2c_master_model_inst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_line));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic settings_type upd(settings_type s, logic [2:0] a, logic [7:0] d);
        case (a)
            3'h0: begin
                s.zero_cross_mode_flag = d[7];
                s.contour_disable_flag = d[6];
                s.volume_code = d[5:0];
            end
            3'h1: s.front_right_attenuator = d[5:0];
            3'h2: s.front_left_attenuator = d[5:0];
            3'h3: s.rear_right_attenuator = d[5:0];
            3'h4: s.rear_left_attenuator = d[5:0];
            3'h5: s.low_tone_setting = d[4:0];
            3'h6: s.high_tone_setting = d[4:0];
            default: begin
                s.global_silence_flag = d[7];
                s.source_code = d[2:0];
            end
        endcase
        return s;
    endfunction

    // Data comes from dq while it holds bytes, otherwise at random
    task automatic xfer(input logic [7:0] adr, input logic [7:0] sub, input int cnt, input logic ok);
        logic [7:0] d;
        logic [2:0] a;
        logic       k;
        @(posedge clk_i);
        #1.3;
        i2c_master_model_inst.start();
        i2c_master_model_inst.put(adr, k);
        chk(64'(k), 64'(ok));
        i2c_master_model_inst.put(sub, k);
        chk(64'(k), 64'(ok));
        a = sub[2:0];
        for (int i = 0; i < cnt; i++) begin
            d = (dq.size() > 0) ? dq.pop_front() : 8'($urandom);
            i2c_master_model_inst.put(d, k);
            chk(64'(k), 64'(ok));
            if (ok) exp_s = upd(exp_s, a, d);
            a = a + 3'h1;
        end
        i2c_master_model_inst.stop();
        repeat (8) @(posedge clk_i);
        chk(64'(settings_o), 64'(exp_s));
    endtask

    task automatic wait_mute(input logic [1:0] v, input int lim);
        n = 0;
        while (channel_mute_o !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk(64'(channel_mute_o), 64'(v));
        if (n >= lim) tally_and_finish();
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        n = $urandom(32'hca80cbd2);
        exp_s = SETTINGS_RESET;
        repeat (10) @(posedge clk_i);
        chk(64'(settings_o), 64'(SETTINGS_RESET));
        chk(64'(channel_mute_o), 64'h3);
        chk(64'(sda_oe_n_o), 64'h1);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        $display("test reset done");
        for (int r = 0; r < 3; r++) xfer(DEVICE_BUS_ADDRESS, 8'h00, 8, 1'b1);
        xfer(DEVICE_BUS_ADDRESS, {5'($urandom), 3'h5}, 6, 1'b1);
        $display("test register writes done");
        xfer(DEVICE_BUS_ADDRESS | 8'h01, 8'h00, 2, 1'b0);
        xfer(DEVICE_BUS_ADDRESS ^ {7'($urandom % 127 + 1), 1'b0}, 8'h00, 2, 1'b0);
        $display("test foreign address done");
        dq = '{8'h00, 8'h05};
        xfer(DEVICE_BUS_ADDRESS, 8'h07, 2, 1'b1);
        wait_mute(2'b00, 20);
        mute_n_i <= 1'b0;
        wait_mute(2'b11, 10);
        chk(64'(settings_o), 64'(exp_s));
        mute_n_i <= 1'b1;
        wait_mute(2'b00, 200);
        $display("test hardware mute done");
        dq = '{8'h80};
        xfer(DEVICE_BUS_ADDRESS, 8'h00, 1, 1'b1);
        dq = '{8'h80};
        xfer(DEVICE_BUS_ADDRESS, 8'h07, 1, 1'b1);
        repeat (20) @(posedge clk_i);
        chk(64'(channel_mute_o), 64'h0);
        zero_cross_i <= 2'b01;
        repeat (6) @(posedge clk_i);
        zero_cross_i <= 2'b00;
        chk(64'(channel_mute_o), 64'h1);
        wait_mute(2'b11, 300);
        chk(64'(n > 100), 64'h1);
        $display("test zero crossing mute done");
        tally_and_finish();
    end
endmodule // audio_control_i2c_slave_test
